// ===== pkg/actuator_pkg.sv
// constants and types for the actuator binary command and block retry logic
// assumes a single 50 MHz clock with synchronous active-high reset
`default_nettype none

package actuator_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned BACKOFF_MAX_MS  = 2000;
  localparam int unsigned BACKOFF_MAX_CYC = (CLK_HZ / 1000) * BACKOFF_MAX_MS;
  localparam int unsigned TICK_US         = 1000;
  localparam int unsigned TICK_CYC        = (CLK_HZ / 1_000_000) * TICK_US;

  // ==========================================================================
  // settings
  localparam logic [2:0]  RETRY_MAX       = 3'h5;
  localparam logic [2:0]  RETRY_RESET     = 3'h0;
  localparam int unsigned TIME_W          = 20;

  // ==========================================================================
  // control modes and motion state
  typedef enum logic [1:0] {
    MODE_PERMANENT    = 2'h0,
    MODE_PULSE        = 2'h1,
    MODE_PROPORTIONAL = 2'h3
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_RUN     = 3'h1,
    ST_BACKOFF = 3'h3,
    ST_RETRY   = 3'h2,
    ST_TRIPPED = 3'h6
  } state_t;

endpackage

`default_nettype wire

// ===== src/input_sync.sv
// three-flop synchroniser with agreement filter for asynchronous pins
// assumes pins are slow levels compared with clk
`timescale 1ns/1ns
`default_nettype none

module input_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // ==========================================================================
  // sync chain; first flop feeds only the second
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================================
  // a change counts once the last two stages agree
  always_ff @(posedge clk)
  begin
    if (rst)
      level <= 1'b0;
    else if (s2_q == s3_q)
      level <= s3_q;
  end

endmodule

`default_nettype wire

// ===== src/actuator_motion.sv
// binary command interpretation and torque block retry sequence
// assumes end position, range and torque flags are pins from the drive; settings static
`timescale 1ns/1ns
`default_nettype none

// Operation
// - blocking outside end range retries the approach 1 to 5 times
// - retry count zero means no retry after a block
// - each retry backs off for range travel, at most 2 s, then re-approaches
// - retries continue until block passed or tries equal the setting
// - after the last failed retry stop motor and flag blocked fault
// - ready stays asserted after a blocked trip
// - retry count setting resets to zero
// - permanent contact moves only while open or close is held
// - permanent contact stops on release, end position, or both inputs
// - permanent contact is default unless positioner option fitted
// - pulse contact latches direction until stop or end position
// - opposite pulse reverses direction at once
// - pulse contact only allowed while alternative mode inactive
// - proportional move travel fraction equals command time over total time
// - total positioning time measured automatically after end setup
// - proportional move only allowed with positioner enabled
// - torque trip outside end range counts as blocked fault
module actuator_motion
  import actuator_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       cmd_open_pin,
  input  wire logic       cmd_close_pin,
  input  wire logic       cmd_stop_pin,
  input  wire logic       torque_trip,
  input  wire logic       at_open_end,
  input  wire logic       at_close_end,
  input  wire logic       in_end_range,
  input  wire logic       positioner_en,
  input  wire logic       alt_mode_active,
  input  wire logic [1:0] mode_sel,
  input  wire logic       mode_write,
  input  wire logic [2:0] retry_set,
  input  wire logic       retry_write,
  input  wire logic       setup_done,
  input  wire logic       fault_clear,
  output logic            motor_open,
  output logic            motor_close,
  output logic            blocked_fault,
  output logic            ready,
  output logic [1:0]      mode,
  output logic [2:0]      retry_count,
  output logic [TIME_W-1:0] total_time
);

  // ==========================================================================
  // synchronised command pins
  logic open_lv;
  logic close_lv;
  logic stop_lv;
  logic open_d1_q;
  logic close_d1_q;
  logic open_edge;
  logic close_edge;

  input_sync u_open  (.clk(clk), .rst(rst), .pin(cmd_open_pin),  .level(open_lv));
  input_sync u_close (.clk(clk), .rst(rst), .pin(cmd_close_pin), .level(close_lv));
  input_sync u_stop  (.clk(clk), .rst(rst), .pin(cmd_stop_pin),  .level(stop_lv));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      open_d1_q  <= 1'b0;
      close_d1_q <= 1'b0;
    end
    else
    begin
      open_d1_q  <= open_lv;
      close_d1_q <= close_lv;
    end
  end

  assign open_edge  = open_lv & ~open_d1_q;
  assign close_edge = close_lv & ~close_d1_q;

  // ==========================================================================
  // millisecond tick for time measurement
  logic [15:0] tick_cnt_q;
  logic        tick;

  assign tick = (tick_cnt_q == 16'(TICK_CYC - 1));

  always_ff @(posedge clk)
  begin
    if (rst || tick)
      tick_cnt_q <= 16'h0000;
    else
      tick_cnt_q <= tick_cnt_q + 16'h0001;
  end

  // ==========================================================================
  // settings: mode and retry count
  always_ff @(posedge clk)
  begin
    if (rst)
      mode <= positioner_en ? 2'(MODE_PROPORTIONAL) : 2'(MODE_PERMANENT);
    else if (mode_write)
    begin
      if (mode_sel == 2'(MODE_PULSE) && !alt_mode_active)
        mode <= mode_sel;
      else if (mode_sel == 2'(MODE_PROPORTIONAL) && positioner_en)
        mode <= mode_sel;
      else if (mode_sel == 2'(MODE_PERMANENT))
        mode <= mode_sel;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      retry_count <= RETRY_RESET;
    else if (retry_write && retry_set <= RETRY_MAX)
      retry_count <= retry_set;
  end

  // ==========================================================================
  // total positioning time measurement
  logic             meas_q;
  logic             meas_done_q;
  logic [TIME_W-1:0] meas_cnt_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meas_q      <= 1'b0;
      meas_done_q <= 1'b0;
      meas_cnt_q  <= '0;
      total_time  <= '0;
    end
    else if (setup_done && !meas_q)
    begin
      meas_q      <= 1'b1;
      meas_done_q <= 1'b0;
      meas_cnt_q  <= '0;
    end
    else if (meas_q)
    begin
      if ((motor_open && at_open_end) || (motor_close && at_close_end))
      begin
        meas_q      <= 1'b0;
        meas_done_q <= 1'b1;
        total_time  <= meas_cnt_q;
      end
      else if (tick && (motor_open || motor_close))
        meas_cnt_q <= meas_cnt_q + TIME_W'(1);
    end
  end

  // ==========================================================================
  // command interpretation per mode
  logic want_open;
  logic want_close;
  logic pulse_open_q;
  logic pulse_close_q;

  always_ff @(posedge clk)
  begin
    if (rst || mode != 2'(MODE_PULSE) || stop_lv)
    begin
      pulse_open_q  <= 1'b0;
      pulse_close_q <= 1'b0;
    end
    else if (open_edge && !close_edge)
    begin
      pulse_open_q  <= 1'b1;
      pulse_close_q <= 1'b0;
    end
    else if (close_edge && !open_edge)
    begin
      pulse_open_q  <= 1'b0;
      pulse_close_q <= 1'b1;
    end
    else if ((pulse_open_q && at_open_end) || (pulse_close_q && at_close_end))
    begin
      pulse_open_q  <= 1'b0;
      pulse_close_q <= 1'b0;
    end
  end

  always_comb
  begin
    want_open  = 1'b0;
    want_close = 1'b0;
    unique case (mode)
      2'(MODE_PULSE):
      begin
        want_open  = pulse_open_q;
        want_close = pulse_close_q;
      end
      // hold time maps to travel; start is immediate so short commands count
      2'(MODE_PROPORTIONAL):
      begin
        want_open  = open_lv & ~close_lv & meas_done_q;
        want_close = close_lv & ~open_lv & meas_done_q;
      end
      default:
      begin
        want_open  = open_lv & ~close_lv;
        want_close = close_lv & ~open_lv;
      end
    endcase
    if (meas_q)
    begin
      want_open  = open_lv & ~close_lv;
      want_close = close_lv & ~open_lv;
    end
  end

  // ==========================================================================
  // motion and block retry sequence
  state_t      state_q;
  logic        dir_open_q;
  logic [2:0]  tries_q;
  logic [26:0] back_cnt_q;
  logic        block_hit;
  logic        end_hit;

  assign block_hit = torque_trip & ~in_end_range;
  assign end_hit   = dir_open_q ? at_open_end : at_close_end;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q       <= ST_IDLE;
      dir_open_q    <= 1'b0;
      tries_q       <= 3'h0;
      back_cnt_q    <= '0;
      blocked_fault <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          tries_q <= 3'h0;
          if (want_open && !at_open_end)
          begin
            dir_open_q <= 1'b1;
            state_q    <= ST_RUN;
          end
          else if (want_close && !at_close_end)
          begin
            dir_open_q <= 1'b0;
            state_q    <= ST_RUN;
          end
        end
        ST_RUN, ST_RETRY:
        begin
          if (block_hit)
          begin
            if (tries_q >= retry_count)
            begin
              state_q       <= ST_TRIPPED;
              blocked_fault <= 1'b1;
            end
            else
            begin
              tries_q    <= tries_q + 3'h1;
              back_cnt_q <= '0;
              state_q    <= ST_BACKOFF;
            end
          end
          else if (end_hit)
            state_q <= ST_IDLE;
          else if (state_q == ST_RUN)
          begin
            // reversal or release ends this run
            if (dir_open_q ? !want_open : !want_close)
              state_q <= ST_IDLE;
          end
          else if (!in_end_range && !(dir_open_q ? want_open : want_close))
            state_q <= ST_IDLE;
        end
        ST_BACKOFF:
        begin
          // back off range travel capped at 2 s
          back_cnt_q <= back_cnt_q + 27'h1;
          if (in_end_range || back_cnt_q == 27'(BACKOFF_MAX_CYC - 1))
            state_q <= ST_RETRY;
        end
        default:
        begin
          // tripped: only the opposite direction may move again
          if (fault_clear)
            blocked_fault <= 1'b0;
          if (dir_open_q ? (want_close && !at_close_end) : (want_open && !at_open_end))
          begin
            dir_open_q    <= ~dir_open_q;
            tries_q       <= 3'h0;
            blocked_fault <= 1'b0;
            state_q       <= ST_RUN;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // motor drive outputs from flops
  logic run_on;

  // drive off at trip; the fault flag and the stop land on one edge
  assign run_on = (state_q == ST_RUN || state_q == ST_RETRY) && !block_hit;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      motor_open  <= 1'b0;
      motor_close <= 1'b0;
    end
    else
    begin
      motor_open  <= run_on ? dir_open_q
                   : (state_q == ST_BACKOFF) ? ~dir_open_q : 1'b0;
      motor_close <= run_on ? ~dir_open_q
                   : (state_q == ST_BACKOFF) ? dir_open_q : 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      ready <= 1'b0;
    else
      ready <= 1'b1;
  end

endmodule

`default_nettype wire

// ===== verif/actuator_motion_asserts.sv
// checker for the actuator motion block, port view only
// assumes one clock domain and synchronous active-high reset
`timescale 1ns/1ns
`default_nettype none

module actuator_motion_asserts
  import actuator_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       torque_trip,
  input wire logic       at_open_end,
  input wire logic       in_end_range,
  input wire logic       positioner_en,
  input wire logic       alt_mode_active,
  input wire logic       motor_open,
  input wire logic       motor_close,
  input wire logic       blocked_fault,
  input wire logic       ready,
  input wire logic [1:0] mode,
  input wire logic [2:0] retry_count
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_retry_rst;
    rst |=> retry_count == 3'h0;
  endproperty
  a_retry_rst: assert property (disable iff (1'b0) p_retry_rst)
    else $error("retry count not cleared by reset");

  property p_retry_max;
    retry_count <= 3'h5;
  endproperty
  a_retry_max: assert property (p_retry_max) else $error("retry count above five");

  property p_ready_fault;
    blocked_fault |-> ready;
  endproperty
  a_ready_fault: assert property (p_ready_fault) else $error("ready lost on block");

  property p_fault_stop;
    $rose(blocked_fault) |-> !motor_open && !motor_close;
  endproperty
  a_fault_stop: assert property (p_fault_stop) else $error("motor runs at trip");

  property p_no_retry;
    retry_count == 3'h0 && motor_open && torque_trip && !in_end_range
      |-> ##[1:3] (blocked_fault && !motor_open && !motor_close);
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("zero count retried");

  property p_end_stop;
    motor_open && at_open_end |-> ##[1:3] !motor_open;
  endproperty
  a_end_stop: assert property (p_end_stop) else $error("open end not honoured");

  property p_one_dir;
    !(motor_open && motor_close);
  endproperty
  a_one_dir: assert property (p_one_dir) else $error("both motor drives on");

  property p_mode_legal;
    mode != 2'h2 && (mode != MODE_PROPORTIONAL || positioner_en)
      && (mode != MODE_PULSE || !alt_mode_active);
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("illegal mode held");
endmodule

`default_nettype wire

// ===== verif/plant_ctrl_model.sv
// plant control system driving the open, close and stop command pins
// assumes requests from the bench change just after a rising edge
`timescale 1ns/1ns
`default_nettype none

module plant_ctrl_model (
  input  wire logic clk,
  input  wire logic open_req,
  input  wire logic close_req,
  input  wire logic stop_req,
  output logic      open_pin,
  output logic      close_pin,
  output logic      stop_pin
);
  // ==========================================================================
  // pin drivers: levels only, the device filters them itself
  initial {open_pin, close_pin, stop_pin} = 3'h0;
  always @(posedge clk)
  begin
    open_pin  <= open_req;
    close_pin <= close_req;
    stop_pin  <= stop_req;
  end
endmodule

`default_nettype wire

// ===== verif/test_actuator_motion.sv
// self-checking bench for the actuator motion block
// assumes the command pins reach the motor within ten cycles
`timescale 1ns/1ns
`default_nettype none

module test_actuator_motion
  import actuator_pkg::*;
;
  logic clk = 0, rst = 1, op = 0, cl = 0, sp = 0, trip = 0, oend = 0, rng = 0;
  logic alt = 0, mw = 0, rw = 0, fclr = 0, pos = 0, sd = 0;
  logic [1:0] msel = 2'h0;
  logic [2:0] rset = 3'h0;
  wire logic op_p, cl_p, sp_p, m_o, m_c, flt, rdy;
  wire logic [1:0] mode;
  wire logic [2:0] rc;
  wire logic [TIME_W-1:0] ttime;
  int miscompares = 0, cmp_count = 0;

  // ==========================================================================
  // clock, partner, design
  always #10 clk = ~clk;
  plant_ctrl_model plant_ctrl_model_inst (.clk(clk), .open_req(op), .close_req(cl),
    .stop_req(sp), .open_pin(op_p), .close_pin(cl_p), .stop_pin(sp_p));
  actuator_motion actuator_motion_inst (.clk(clk), .rst(rst), .cmd_open_pin(op_p),
    .cmd_close_pin(cl_p), .cmd_stop_pin(sp_p), .torque_trip(trip), .at_open_end(oend),
    .at_close_end(1'b0), .in_end_range(rng), .positioner_en(pos),
    .alt_mode_active(alt), .mode_sel(msel), .mode_write(mw), .retry_set(rset),
    .retry_write(rw), .setup_done(sd), .fault_clear(fclr), .motor_open(m_o),
    .motor_close(m_c), .blocked_fault(flt), .ready(rdy), .mode(mode),
    .retry_count(rc), .total_time(ttime));

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input string n, input logic [TIME_W-1:0] e, input logic [TIME_W-1:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task set_mode(input logic [1:0] m);
    msel <= m; mw <= 1; tick(1); mw <= 0; tick(2);
  endtask
  task set_retry(input logic [2:0] r);
    rset <= r; rw <= 1; tick(1); rw <= 0; tick(2);
  endtask
  // a trip holds the same direction locked; only an opposite move leaves it
  task clear_trip;
    trip <= 0;
    op <= 0;
    fclr <= 1;
    tick(1);
    fclr <= 0;
    tick(10);
    chk("cleared", 3'h0, {2'h0, flt});
    cl <= 1;
    tick(10);
    chk("opposite", 3'h1, {1'b0, m_o, m_c});
    cl <= 0;
    tick(10);
  endtask
  task end_of_test;
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================================
  // watchdog: the whole sequence needs well under 2000 cycles
  initial
  begin
    tick(20000);
    miscompares++;
    end_of_test();
  end

  initial
  begin
    tick(6);
    rst <= 0;
    tick(2);
    chk("mode", {1'b0, MODE_PERMANENT}, {1'b0, mode});
    chk("retry", 3'h0, rc);
    chk("ready", 3'h1, {2'h0, rdy});
    // permanent contact: hold, both, end position, release
    op <= 1; tick(10);
    chk("open", 3'h1, {2'h0, m_o});
    cl <= 1; tick(10);
    chk("both", 3'h0, {1'b0, m_o, m_c});
    cl <= 0; tick(10);
    oend <= 1; tick(4);
    chk("end", 3'h0, {2'h0, m_o});
    oend <= 0; op <= 0; tick(10);
    chk("release", 3'h0, {1'b0, m_o, m_c});
    // zero count: first block trips at once
    op <= 1; tick(10); trip <= 1; tick(4);
    chk("fault0", 3'h6, {flt, rdy, m_o});
    clear_trip();
    set_retry(3'h7);
    chk("retry7", 3'h0, rc);
    set_retry(3'h2);
    chk("retry2", 3'h2, rc);
    op <= 1; tick(10);
    for (int i = 0; i < 2; i++)
    begin
      trip <= 1; tick(4);
      // back-off drives against the blocked direction
      chk("backoff", 3'h1, {1'b0, m_o, m_c});
      trip <= 0; rng <= 1; tick(4); rng <= 0; tick(3);
      chk("reapproach", 3'h2, {1'b0, m_o, m_c});
    end
    trip <= 1; tick(4);
    chk("trip2", 3'h6, {flt, rdy, m_o});
    clear_trip();
    // pulse contact: latch, reverse, stop, refused writes
    set_mode(MODE_PULSE);
    chk("pulse", {1'b0, MODE_PULSE}, {1'b0, mode});
    op <= 1; tick(8); op <= 0; tick(10);
    chk("latch", 3'h2, {1'b0, m_o, m_c});
    cl <= 1; tick(8); cl <= 0; tick(4);
    chk("reverse", 3'h1, {1'b0, m_o, m_c});
    sp <= 1; tick(8); sp <= 0; tick(4);
    chk("stop", 3'h0, {1'b0, m_o, m_c});
    set_mode(2'h2);
    chk("code2", {1'b0, MODE_PULSE}, {1'b0, mode});
    set_mode(MODE_PROPORTIONAL);
    chk("prop", {1'b0, MODE_PULSE}, {1'b0, mode});
    set_mode(MODE_PERMANENT); alt <= 1; tick(2);
    set_mode(MODE_PULSE);
    chk("alt", {1'b0, MODE_PERMANENT}, {1'b0, mode});
    // positioner fitted: reset while stopped, then proportional move once run time is known
    pos <= 1;
    rst <= 1;
    tick(2);
    rst <= 0;
    tick(2);
    chk("mode_pos", {1'b0, MODE_PROPORTIONAL}, {1'b0, mode});
    chk("retry_rst", 3'h0, rc);
    op <= 1;
    tick(10);
    chk("unmeasured", 3'h0, {1'b0, m_o, m_c});
    op <= 0;
    tick(10);
    sd <= 1;
    tick(1);
    sd <= 0;
    op <= 1;
    tick(10);
    chk("measure", 3'h2, {1'b0, m_o, m_c});
    oend <= 1;
    tick(4);
    op <= 0;
    tick(10);
    oend <= 0;
    // measured run is far shorter than one 1 ms tick after the reset
    chk("run_time", 20'h00000, ttime);
    op <= 1;
    tick(10);
    chk("prop_move", 3'h2, {1'b0, m_o, m_c});
    op <= 0;
    tick(10);
    chk("prop_stop", 3'h0, {1'b0, m_o, m_c});
    end_of_test();
  end
endmodule

bind actuator_motion actuator_motion_asserts actuator_motion_asserts_inst (.clk(clk),
  .rst(rst), .torque_trip(torque_trip), .at_open_end(at_open_end),
  .in_end_range(in_end_range), .positioner_en(positioner_en),
  .alt_mode_active(alt_mode_active), .motor_open(motor_open),
  .motor_close(motor_close), .blocked_fault(blocked_fault), .ready(ready),
  .mode(mode), .retry_count(retry_count));

`default_nettype wire
